// >>> cpu_ops_consts.svh
`ifndef CPU_OPS_CONSTS_SVH
`define CPU_OPS_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_INSTR 10'h000
`define OFF_WORKING 10'h004
`define OFF_STATUS 10'h008
`define OFF_PCLATCH 10'h00c
`define OFF_PC 10'h010
`define OFF_STACK 10'h014
`define OFF_WDOG 10'h018
`define FILE_BASE_BIT 9

// ----------------------------------------
// field positions
// ----------------------------------------
`define INSTR_F_LSB 0
`define INSTR_D_BIT 7
`define INSTR_OP_LSB 8
`define INSTR_BUSY_BIT 31
`define STAT_Z_BIT 0
`define STAT_PD_BIT 1
`define STAT_TO_BIT 2
`define STACK_PTR_LSB 16

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_PC 15'h0000
`define RST_FLAG_N 1'b1
`define DATA_ZERO 32'h0000_0000
`define WDOG_CLEAR 8'h00

`endif

// >>> cpu_ops_pkg.sv
package cpu_ops_pkg;

	typedef enum logic [2:0] {
		OP_NOP,
		OP_WATCHDOG_CLEAR,
		OP_CALL_VIA_WORKING,
		OP_COMPLEMENT_FILE,
		OP_CLEAR_FILE,
		OP_DECREMENT_FILE,
		OP_CLEAR_WORKING,
		OP_DECREMENT_SKIP_ZERO
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_SECOND
	} state_t;

	typedef struct packed {
		op_t op;
		logic dest_file;
		logic [6:0] faddr;
	} instr_t;

	typedef struct packed {
		logic timeout_flag_n;
		logic powerdown_flag_n;
		logic zero;
	} status_t;

endpackage : cpu_ops_pkg

// >>> cpu_clear_call_decrement_ops.sv
`timescale 1ns/1ps
`include "cpu_ops_consts.svh"

// Behaviour
// - watchdog clear zeroes the watchdog counter and prescaler and sets both the timeout and powerdown flags.
// - call via working pushes pc plus one on the return stack one cycle before pc loads the call target.
// - call via working loads pc low byte from working and pc high bits from the high latch.
// - call via working takes two cycles and leaves every status flag alone.
// - complement writes the inverted file value to working or file by the destination bit.
// - clear file writes zero to the file register and always sets the zero flag.
// - decrement writes file minus one to working or file by destination and updates zero.
// - clear working loads zero into working and sets the zero flag.
// - decrement skip stores file minus one by destination and touches no status flag.
// - a zero decrement-skip result discards the next instruction as a one-cycle no-op.
module cpu_clear_call_decrement_ops #(
	parameter int STACK_DEPTH = 16,
	parameter int PRESCALE_WIDTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o
);

	localparam int SP_W = $clog2(STACK_DEPTH);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	function automatic logic is_zero(input logic [7:0] v);
		return v == `RST_BYTE;
	endfunction : is_zero

	// ----------------------------------------
	// state
	// ----------------------------------------
	cpu_ops_pkg::state_t state_r;
	cpu_ops_pkg::instr_t instr_r;
	cpu_ops_pkg::status_t status_r;
	logic [7:0] working_r;
	logic [6:0] pc_high_latch_r;
	logic [14:0] pc_r;
	logic [7:0] watchdog_counter_r;
	logic [PRESCALE_WIDTH-1:0] prescale_r;
	logic [SP_W-1:0] sp_r;
	logic [14:0] stack_r [STACK_DEPTH];
	logic [7:0] file_r [128];
	logic ack_r;
	logic [31:0] rdata_r;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire req = cyc_i & stb_i;
	wire bus_wr = req & we_i & ack_r;
	wire hit_file = adr_i[`FILE_BASE_BIT];
	wire [6:0] bus_faddr = adr_i[8:2];
	wire hit_instr = !hit_file && adr_i == `OFF_INSTR;
	wire hit_working = !hit_file && adr_i == `OFF_WORKING;
	wire hit_status = !hit_file && adr_i == `OFF_STATUS;
	wire hit_latch = !hit_file && adr_i == `OFF_PCLATCH;
	wire hit_pc = !hit_file && adr_i == `OFF_PC;
	wire hit_stack = !hit_file && adr_i == `OFF_STACK;
	wire hit_wdog = !hit_file && adr_i == `OFF_WDOG;
	wire busy = state_r != cpu_ops_pkg::ST_IDLE;
	// a new instruction while one is running is dropped, not queued
	wire go = bus_wr & hit_instr & !busy & sel_i[1];

	// ----------------------------------------
	// execution datapath
	// ----------------------------------------
	wire exec = state_r == cpu_ops_pkg::ST_EXEC;
	wire second = state_r == cpu_ops_pkg::ST_SECOND;
	wire cpu_ops_pkg::op_t op = instr_r.op;
	wire [7:0] fval = file_r[instr_r.faddr];
	wire [7:0] dec_val = fval - 8'h01;
	wire [7:0] com_val = ~fval;
	wire is_com = op == cpu_ops_pkg::OP_COMPLEMENT_FILE;
	wire is_dec = op == cpu_ops_pkg::OP_DECREMENT_FILE;
	wire is_dsz = op == cpu_ops_pkg::OP_DECREMENT_SKIP_ZERO;
	wire is_clear_file_op = op == cpu_ops_pkg::OP_CLEAR_FILE;
	wire is_clear_working_op = op == cpu_ops_pkg::OP_CLEAR_WORKING;
	wire is_call = op == cpu_ops_pkg::OP_CALL_VIA_WORKING;
	wire is_wclr = op == cpu_ops_pkg::OP_WATCHDOG_CLEAR;
	wire has_dest = is_com | is_dec | is_dsz;
	wire [7:0] com_or_zero = is_com ? com_val : `RST_BYTE;
	wire [7:0] result = (is_dec | is_dsz) ? dec_val : com_or_zero;
	wire wr_file = exec & (is_clear_file_op | (has_dest & instr_r.dest_file));
	wire wr_working = exec & (is_clear_working_op | (has_dest & !instr_r.dest_file));
	// no flag update for skip form
	wire upd_zero = exec & (is_com | is_dec | is_clear_file_op | is_clear_working_op);
	wire zero_nxt = (is_clear_file_op | is_clear_working_op) ? 1'b1 : is_zero(result);
	wire skip = is_dsz & is_zero(dec_val);
	wire two_cycle = is_call | skip;
	wire [14:0] pc_inc = pc_r + 15'h0001;
	wire [14:0] call_target = {pc_high_latch_r, working_r};
	wire [31:0] pc_wr_word = merge({17'h0_0000, pc_r}, dat_i, sel_i);
	wire [SP_W-1:0] sp_top = sp_r - 1'b1;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			state_r <= cpu_ops_pkg::ST_IDLE;
		else
			case (state_r)
				cpu_ops_pkg::ST_IDLE:
					if (go)
						state_r <= cpu_ops_pkg::ST_EXEC;
				cpu_ops_pkg::ST_EXEC:
					state_r <= two_cycle ? cpu_ops_pkg::ST_SECOND : cpu_ops_pkg::ST_IDLE;
				default:
					state_r <= cpu_ops_pkg::ST_IDLE;
			endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			instr_r <= '0;
		else if (go)
			instr_r <= dat_i[10:0];
	end

	// ----------------------------------------
	// program counter and stack
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			pc_r <= `RST_PC;
		else if (second & is_call)
			pc_r <= call_target;
		// a skipped slot still advances pc past the discarded word
		else if (exec | second)
			pc_r <= pc_inc;
		else if (bus_wr & hit_pc)
			pc_r <= pc_wr_word[14:0];
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sp_r <= '0;
			for (int i = 0; i < STACK_DEPTH; i++)
			begin
				stack_r[i] <= `RST_PC;
			end
		end
		else if (exec & is_call)
		begin
			stack_r[sp_r] <= pc_inc;
			sp_r <= sp_r + 1'b1;
		end
	end

	// ----------------------------------------
	// working, latch, file registers
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			working_r <= `RST_BYTE;
		else if (wr_working)
			working_r <= result;
		else if (bus_wr & hit_working & sel_i[0])
			working_r <= dat_i[7:0];
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			pc_high_latch_r <= 7'h00;
		else if (bus_wr & hit_latch & sel_i[0])
			pc_high_latch_r <= dat_i[6:0];
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < 128; i++)
			begin
				file_r[i] <= `RST_BYTE;
			end
		end
		else if (wr_file)
		begin
			file_r[instr_r.faddr] <= result;
		end
		else if (bus_wr & hit_file & sel_i[0])
		begin
			file_r[bus_faddr] <= dat_i[7:0];
		end
	end

	// ----------------------------------------
	// status and watchdog
	// ----------------------------------------
	wire wdog_clear = exec & is_wclr;
	wire wdog_overflow = &{watchdog_counter_r, prescale_r};

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			status_r <= {`RST_FLAG_N, `RST_FLAG_N, 1'b0};
		end
		else
		begin
			if (bus_wr & hit_status & sel_i[0])
			begin
				status_r <= dat_i[2:0];
			end
			if (upd_zero)
			begin
				status_r.zero <= zero_nxt;
			end
			if (wdog_clear)
			begin
				status_r.timeout_flag_n <= 1'b1;
				status_r.powerdown_flag_n <= 1'b1;
			end
			else if (wdog_overflow)
			begin
				status_r.timeout_flag_n <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			watchdog_counter_r <= `WDOG_CLEAR;
			prescale_r <= '0;
		end
		else if (wdog_clear)
		begin
			watchdog_counter_r <= `WDOG_CLEAR;
			prescale_r <= '0;
		end
		else
		begin
			prescale_r <= prescale_r + 1'b1;
			if (&prescale_r)
			begin
				watchdog_counter_r <= watchdog_counter_r + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// read mux and acknowledge
	// ----------------------------------------
	wire [31:0] rd_instr = (32'(busy) << `INSTR_BUSY_BIT) | 32'(instr_r);
	wire [31:0] rd_stack = (32'(sp_r) << `STACK_PTR_LSB) | 32'(stack_r[sp_top]);
	// unmapped addresses fall through to zero
	wire [31:0] rmux = hit_file ? 32'(file_r[bus_faddr]) :
		hit_instr ? rd_instr :
		hit_working ? 32'(working_r) :
		hit_status ? 32'(status_r) :
		hit_latch ? 32'(pc_high_latch_r) :
		hit_pc ? 32'(pc_r) :
		hit_stack ? rd_stack :
		hit_wdog ? 32'(watchdog_counter_r) : `DATA_ZERO;

	// one wait state; the ack drops the cycle after it was given
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			rdata_r <= `DATA_ZERO;
		end
		else
		begin
			ack_r <= req & !ack_r;
			if (req & !ack_r)
			begin
				rdata_r <= rmux;
			end
		end
	end

	assign ack_o = ack_r;
	assign dat_o = rdata_r;

endmodule : cpu_clear_call_decrement_ops

// >>> ops_properties.sv
`timescale 1ns/1ps
module ops_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// read answer seen at the slave's acknowledge
	wire rd_w = ack_o && !we_i;

	AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
		else $error("ack held too long");
	AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	AST_ACK_WAIT: assert property ($rose(cyc_i && stb_i) |=> ack_o)
		else $error("ack not one wait state late");
	AST_WDOG_BYTE: assert property (rd_w && adr_i[9:2] == 8'h06 |-> dat_o[31:8] == '0)
		else $error("watchdog read too wide");
	AST_PC_WIDTH: assert property (rd_w && adr_i[9:2] == 8'h04 |-> dat_o[31:15] == '0)
		else $error("pc read too wide");
	AST_STACK_FIELDS: assert property (rd_w && adr_i[9:2] == 8'h05 |-> !dat_o[15])
		else $error("stack entry too wide");
	AST_STATUS_BITS: assert property (rd_w && adr_i[9:2] == 8'h02 |-> dat_o[31:3] == '0)
		else $error("status read too wide");
	AST_FILE_BYTE: assert property (rd_w && adr_i[9] |-> dat_o[31:8] == '0)
		else $error("file read too wide");
endmodule : ops_checker

bind cpu_clear_call_decrement_ops ops_checker u_ops_checker (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o));

// >>> tb.sv
`timescale 1ns/1ps
module tb;
	logic clk_i = 0;
	logic rst_i = 1;
	logic cyc_i = 0;
	logic stb_i = 0;
	logic we_i = 0;
	logic [9:0] adr_i = '0;
	logic [3:0] sel_i = 4'hf;
	logic [31:0] dat_i = '0;
	logic [31:0] dat_o;
	logic ack_o;
	logic [31:0] rd;
	logic [31:0] pc0;
	logic [31:0] sp0;
	int error_cnt = 0;
	int total_checks = 0;
	int cycles = 0;
	int polls = 0;

	always #50 clk_i = ~clk_i;

	cpu_clear_call_decrement_ops u_cpu_clear_call_decrement_ops (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

	// ----------------------------------------
	// bus helpers
	// ----------------------------------------
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		@(posedge clk_i);
		// no fixed latency assumed; the run timeout ends a hang
		while (ack_o !== 1'b1)
			@(posedge clk_i);
		rd = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		@(posedge clk_i);
	endtask : bus

	task automatic rdchk(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(0, a, 32'h0);
		total_checks++;
		if ((rd & m) !== e)
		begin
			$display("Error at %0t: adr %h got %h exp %h", $time, a, rd & m, e);
			error_cnt++;
		end
	endtask : rdchk

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			$display("Error at %0t: got %h exp %h", $time, g, e);
			error_cnt++;
		end
	endtask : chk

	task automatic exec(input logic [2:0] op, input logic d, input logic [6:0] f);
		bus(1, 10'h000, {21'h0, op, d, f});
		rd = 32'h8000_0000;
		polls = 0;
		while (rd[31] !== 1'b0)
		begin
			bus(0, 10'h000, 32'h0);
			polls++;
		end
	endtask : exec

	task automatic t_wdog;
		rdchk(10'h008, 32'hff, 32'h6);
		bus(1, 10'h01c, 32'hff);
		rdchk(10'h01c, 32'hffff_ffff, 32'h0);
		bus(1, 10'h008, 32'h0);
		// let the prescaler wrap once so the clear has something to undo
		repeat (300) @(posedge clk_i);
		bus(0, 10'h018, 32'h0);
		chk(32'(rd[7:0] == 8'h00), 32'h0);
		exec(3'h1, 0, 7'h0);
		rdchk(10'h008, 32'h6, 32'h6);
		rdchk(10'h018, 32'hff, 32'h0);
		$display("wdog test done");
	endtask : t_wdog

	task automatic t_complement_file_op;
		bus(1, 10'h214, 32'hff);
		exec(3'h3, 0, 7'h5);
		rdchk(10'h004, 32'hff, 32'h0);
		rdchk(10'h008, 32'h1, 32'h1);
		rdchk(10'h214, 32'hff, 32'hff);
		exec(3'h3, 1, 7'h5);
		rdchk(10'h214, 32'hff, 32'h0);
		exec(3'h3, 1, 7'h5);
		rdchk(10'h214, 32'hff, 32'hff);
		rdchk(10'h008, 32'h1, 32'h0);
		$display("complement_file_op test done");
	endtask : t_complement_file_op

	task automatic t_decrement_file_op;
		bus(1, 10'h21c, 32'h1);
		exec(3'h5, 0, 7'h7);
		rdchk(10'h004, 32'hff, 32'h0);
		rdchk(10'h008, 32'h1, 32'h1);
		rdchk(10'h21c, 32'hff, 32'h1);
		exec(3'h5, 1, 7'h7);
		exec(3'h5, 1, 7'h7);
		rdchk(10'h21c, 32'hff, 32'hff);
		rdchk(10'h008, 32'h1, 32'h0);
		$display("decrement_file_op test done");
	endtask : t_decrement_file_op

	task automatic t_clr;
		bus(1, 10'h3fc, 32'h5a);
		exec(3'h4, 1, 7'h7f);
		rdchk(10'h3fc, 32'hff, 32'h0);
		rdchk(10'h008, 32'h1, 32'h1);
		bus(1, 10'h004, 32'h33);
		bus(1, 10'h008, 32'h0);
		exec(3'h6, 0, 7'h0);
		rdchk(10'h004, 32'hff, 32'h0);
		rdchk(10'h008, 32'h1, 32'h1);
		$display("clear test done");
	endtask : t_clr

	task automatic t_skip;
		bus(1, 10'h008, 32'h0);
		bus(1, 10'h20c, 32'h2);
		bus(0, 10'h010, 32'h0);
		pc0 = rd;
		exec(3'h7, 1, 7'h3);
		chk(polls, 1);
		rdchk(10'h20c, 32'hff, 32'h1);
		rdchk(10'h010, 32'h7fff, (pc0 + 1) & 32'h7fff);
		bus(1, 10'h004, 32'h5a);
		exec(3'h7, 0, 7'h3);
		chk(polls, 2);
		rdchk(10'h004, 32'hff, 32'h0);
		rdchk(10'h008, 32'h1, 32'h0);
		rdchk(10'h010, 32'h7fff, (pc0 + 3) & 32'h7fff);
		$display("skip test done");
	endtask : t_skip

	task automatic t_call;
		bus(1, 10'h00c, 32'h55);
		bus(1, 10'h004, 32'ha3);
		bus(1, 10'h008, 32'h7);
		bus(0, 10'h010, 32'h0);
		pc0 = rd;
		bus(0, 10'h014, 32'h0);
		sp0 = rd;
		exec(3'h2, 0, 7'h0);
		chk(polls, 2);
		rdchk(10'h010, 32'h7fff, 32'h55a3);
		rdchk(10'h014, 32'h7fff, (pc0 + 1) & 32'h7fff);
		rdchk(10'h014, 32'hf_0000, (sp0 + 32'h1_0000) & 32'hf_0000);
		rdchk(10'h008, 32'h7, 32'h7);
		$display("call test done");
	endtask : t_call

	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			error_cnt++;
			final_report;
		end
	end

	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		t_wdog;
		t_complement_file_op;
		t_decrement_file_op;
		t_clr;
		t_skip;
		t_call;
		final_report;
	end
endmodule : tb
